// ### scb_sriov_bridge.sv
// SR-IOV configuration, BAR check, interrupt and transmit merge bridge
`timescale 1ns/1ns
module scb_sriov_bridge #(
	parameter int CFG_BUDGET = scb_pkg::CFG_BUDGET
) (
	input  logic               clk,
	input  logic               rstn,
	input  logic               peripheryDone,
	output logic               coreRstn,
	output logic               cfgTimeMiss,
	input  logic               coreRxValid,
	input  scb_pkg::scb_tlp_s  coreRxTlp,
	output logic               coreRxReady,
	output logic               appRxValid,
	output scb_pkg::scb_tlp_s  appRxTlp,
	output logic               appRxVfHit,
	input  logic               appRxReady,
	input  logic               appTxValid,
	input  scb_pkg::scb_tlp_s  appTxTlp,
	output logic               appTxReady,
	output logic               coreTxValid,
	output scb_pkg::scb_tlp_s  coreTxTlp,
	input  logic               coreTxReady,
	input  logic               creditReturn,
	input  logic               msiReq,
	input  logic               msixReq,
	input  logic [11:0]        intFunc,
	input  logic [4:0]         msiVector,
	input  logic [31:0]        msixAddr,
	input  logic [31:0]        msixData,
	output logic               intAck,
	input  logic               intxSts,
	input  logic               lmReq,
	input  scb_pkg::scb_lm_s   lmCmd,
	output logic               lmAck,
	output logic [31:0]        lmRdata,
	output logic               coreLmReq,
	output scb_pkg::scb_lm_s   coreLmCmd,
	input  logic               coreLmAck,
	input  logic [31:0]        coreLmRdata,
	output logic               shadowValid,
	output logic [11:0]        shadowFunc,
	output logic [7:0]         shadowCtl
);
	logic                           periphS1, periphS2;
	scb_pkg::scb_rst_e              rstState;
	logic [scb_pkg::HOLD_W-1:0]     holdCnt;
	logic [31:0]                    barMem [scb_pkg::FN_NUM];
	logic [7:0]                     ctlMem [scb_pkg::FN_NUM];
	logic [31:0]                    msiAddr [scb_pkg::PF_NUM];
	logic [31:0]                    msiData [scb_pkg::PF_NUM];
	logic [11:0]                    initIdx;
	logic                           initDone;
	logic                           intValid, next_intValid, intTake, intxSent, next_intxSent;
	logic                           aerPend, next_aerPend, ackNext;
	scb_pkg::scb_tlp_s              intTlp, next_intTlp, next_buf;
	logic                           bufValid, next_bufValid, txSend;
	logic [7:0]                     credit, next_credit;
	logic                           rxFire, fOk, isMem, isCfg, barHit, cfgOk, toApp;
	logic                           next_appRxValid, wrEn, cfgWr, lmLocal;
	logic [11:0]                    wrF, lmF;
	logic [7:0]                     wrReg;
	logic [31:0]                    wrData;

	// Builds one internal packet
	function automatic scb_pkg::scb_tlp_s mkTlp(input logic [7:0] k, input logic [11:0] f,
		input logic [15:0] id, input logic [7:0] t, input logic [31:0] a, input logic [31:0] d);
		mkTlp = '{kind: k, func: f, reqId: id, tag: t, addr: a, data: d};
	endfunction

	// Register numbers that the bridge implements
	function automatic logic cfgKnown(input logic [7:0] r);
		cfgKnown = r == scb_pkg::R_CTL || r == scb_pkg::R_BAR || r == scb_pkg::R_MSI_ADDR
			|| r == scb_pkg::R_MSI_DATA || r == scb_pkg::R_MSIX_TBL || r == scb_pkg::R_MSIX_PBA;
	endfunction

	// Shared read decode for configuration requests and the management port
	function automatic logic [31:0] cfgRead(input logic [11:0] f, input logic [7:0] r);
		logic pf;
		pf = f < scb_pkg::PF_LIM;
		case (r)
			scb_pkg::R_CTL:      cfgRead = {24'h00_0000, ctlMem[f]};
			scb_pkg::R_BAR:      cfgRead = barMem[f];
			scb_pkg::R_MSI_ADDR: cfgRead = pf ? msiAddr[f[2:0]] : 32'h0000_0000;
			scb_pkg::R_MSI_DATA: cfgRead = pf ? msiData[f[2:0]] : 32'h0000_0000;
			scb_pkg::R_MSIX_TBL: cfgRead = scb_pkg::MSIX_TBL_PTR;
			scb_pkg::R_MSIX_PBA: cfgRead = scb_pkg::MSIX_PBA_PTR;
			default:             cfgRead = 32'h0000_0000;
		endcase
	endfunction

	// Periphery-done pin synchroniser
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			periphS1 <= 1'b0;
			periphS2 <= 1'b0;
		end else begin
			periphS1 <= peripheryDone;
			periphS2 <= periphS1;
		end
	end

	// Hard reset controller; a late periphery is flagged, never forced out
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstState    <= scb_pkg::RST_HOLD;
			coreRstn    <= 1'b0;
			holdCnt     <= '0;
			cfgTimeMiss <= 1'b0;
		end else begin
			case (rstState)
				scb_pkg::RST_HOLD: begin
					if (periphS2) begin
						rstState <= scb_pkg::RST_RUN;
						coreRstn <= 1'b1;
					end else if (holdCnt == CFG_BUDGET[scb_pkg::HOLD_W-1:0]) begin
						cfgTimeMiss <= 1'b1;
					end else begin
						holdCnt <= holdCnt + 1'b1;
					end
				end
				scb_pkg::RST_RUN: coreRstn <= 1'b1;
				default:          rstState <= scb_pkg::RST_HOLD;
			endcase
		end
	end

	// Receive decode and BAR check against the target function
	always_comb begin
		rxFire = coreRxValid && coreRxReady;
		fOk    = coreRxTlp.func < scb_pkg::FN_LIM;
		isMem  = coreRxTlp.kind == scb_pkg::K_MRD || coreRxTlp.kind == scb_pkg::K_MWR;
		isCfg  = coreRxTlp.kind == scb_pkg::K_CFGRD || coreRxTlp.kind == scb_pkg::K_CFGWR;
		barHit = fOk && ctlMem[coreRxTlp.func][scb_pkg::C_MEM]
			&& (((coreRxTlp.addr ^ barMem[coreRxTlp.func]) & scb_pkg::BAR_MASK) == '0);
		cfgOk  = fOk && cfgKnown(coreRxTlp.addr[7:0]);
		toApp  = rxFire && !isCfg && (!isMem || barHit);
		next_appRxValid = (appRxValid && !appRxReady) || toApp;
	end

	// Single write port into the configuration store; config requests beat the port
	always_comb begin
		cfgWr   = rxFire && coreRxTlp.kind == scb_pkg::K_CFGWR && cfgOk;
		lmF     = lmCmd.addr[scb_pkg::LM_FN +: 12];
		lmLocal = initDone && lmReq && !lmAck && lmCmd.addr[scb_pkg::LM_SEL] && !(rxFire && isCfg);
		wrEn    = cfgWr || (lmLocal && lmCmd.write && lmF < scb_pkg::FN_LIM);
		wrF     = cfgWr ? coreRxTlp.func : lmF;
		wrReg   = cfgWr ? coreRxTlp.addr[7:0] : lmCmd.addr[7:0];
		wrData  = cfgWr ? coreRxTlp.data : lmCmd.wdata;
	end

	// Function store; cleared by a sweep after reset since it is too big to reset
	always_ff @(posedge clk) begin
		if (!initDone) begin
			barMem[initIdx] <= '0;
			ctlMem[initIdx] <= '0;
		end else if (wrEn && wrReg == scb_pkg::R_CTL) begin
			ctlMem[wrF] <= wrData[7:0];
		end else if (wrEn && wrReg == scb_pkg::R_BAR) begin
			barMem[wrF] <= wrData & scb_pkg::BAR_MASK;
		end
	end

	// Sweep counter and per-physical-function MSI address and data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			initIdx  <= '0;
			initDone <= 1'b0;
			for (int i = 0; i < scb_pkg::PF_NUM; i++) begin
				msiAddr[i] <= '0;
				msiData[i] <= '0;
			end
		end else begin
			if (!initDone) begin
				initIdx  <= initIdx + 1'b1;
				initDone <= initIdx == scb_pkg::FN_LIM - 1'b1;
			end
			if (wrEn && wrF < scb_pkg::PF_LIM && wrReg == scb_pkg::R_MSI_ADDR)
				msiAddr[wrF[2:0]] <= wrData;
			if (wrEn && wrF < scb_pkg::PF_LIM && wrReg == scb_pkg::R_MSI_DATA)
				msiData[wrF[2:0]] <= wrData;
		end
	end

	// Internal packet source: completions first, then errors, INTx, MSI, MSI-X
	always_comb begin
		next_intValid = intValid && !intTake;
		next_intTlp   = intTlp;
		next_intxSent = intxSent;
		next_aerPend  = aerPend;
		ackNext       = 1'b0;
		if (rxFire && isCfg) begin
			next_intValid = 1'b1;
			next_intTlp = mkTlp((cfgOk && coreRxTlp.kind == scb_pkg::K_CFGRD) ? scb_pkg::K_CPLD
				: scb_pkg::K_CPL, coreRxTlp.func, coreRxTlp.reqId, coreRxTlp.tag,
				{29'h0000_0000, cfgOk ? scb_pkg::CPL_SC : scb_pkg::CPL_UR},
				cfgOk ? cfgRead(coreRxTlp.func, coreRxTlp.addr[7:0]) : '0);
			if (!cfgOk)
				next_aerPend = 1'b1;
		end else if (rxFire && coreRxTlp.kind == scb_pkg::K_MRD && !barHit) begin
			next_intValid = 1'b1;
			next_intTlp = mkTlp(scb_pkg::K_CPL, coreRxTlp.func, coreRxTlp.reqId, coreRxTlp.tag,
				{29'h0000_0000, scb_pkg::CPL_UR}, '0);
		end else if (!intValid && aerPend) begin
			next_intValid = 1'b1;
			next_aerPend  = 1'b0;
			next_intTlp = mkTlp(scb_pkg::K_MSG, '0, '0, scb_pkg::M_ERR_NF, '0, '0);
		end else if (!intValid && intxSts != intxSent) begin
			next_intValid = 1'b1;
			next_intxSent = intxSts;
			next_intTlp = mkTlp(scb_pkg::K_MSG, '0, '0, intxSts ? scb_pkg::M_INTA_ON
				: scb_pkg::M_INTA_OFF, '0, '0);
		end else if (!intValid && !intAck && msiReq) begin
			ackNext = 1'b1;
			if (intFunc < scb_pkg::PF_LIM && ctlMem[intFunc][scb_pkg::C_MSI]) begin
				next_intValid = 1'b1;
				next_intTlp = mkTlp(scb_pkg::K_MWR, intFunc, '0, scb_pkg::T_MSI,
					msiAddr[intFunc[2:0]], msiData[intFunc[2:0]] | {27'h000_0000, msiVector});
			end
		end else if (!intValid && !intAck && msixReq) begin
			ackNext = 1'b1;
			if (intFunc < scb_pkg::FN_LIM && ctlMem[intFunc][scb_pkg::C_MSIX]) begin
				next_intValid = 1'b1;
				next_intTlp = mkTlp(scb_pkg::K_MWR, intFunc, '0, scb_pkg::T_MSIX,
					msixAddr, msixData);
			end
		end
	end

	// Transmit merge; a held packet blocks everything behind it until credit returns
	always_comb begin
		txSend        = coreTxValid && coreTxReady;
		next_bufValid = bufValid && !txSend;
		next_buf      = coreTxTlp;
		intTake       = intValid && !next_bufValid;
		if (intTake) begin
			next_bufValid = 1'b1;
			next_buf      = intTlp;
		end else if (!next_bufValid && appTxValid && appTxReady) begin
			next_bufValid = 1'b1;
			next_buf      = appTxTlp;
		end
		next_credit = credit + {7'h00, creditReturn} - {7'h00, txSend};
	end

	// State of the internal slot, transmit stage and credits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			intValid    <= 1'b0;
			intTlp      <= '0;
			intxSent    <= 1'b0;
			aerPend     <= 1'b0;
			intAck      <= 1'b0;
			bufValid    <= 1'b0;
			coreTxTlp   <= '0;
			coreTxValid <= 1'b0;
			credit      <= scb_pkg::CREDIT_INIT;
			appTxReady  <= 1'b0;
			coreRxReady <= 1'b0;
		end else begin
			intValid    <= next_intValid;
			intTlp      <= next_intTlp;
			intxSent    <= next_intxSent;
			aerPend     <= next_aerPend;
			intAck      <= ackNext;
			bufValid    <= next_bufValid;
			coreTxTlp   <= next_buf;
			coreTxValid <= next_bufValid && next_credit != '0;
			credit      <= next_credit;
			appTxReady  <= !next_bufValid && !next_intValid;
			coreRxReady <= initDone && !next_intValid && !next_appRxValid;
		end
	end

	// Receive forward; no request bookkeeping, arrival order kept
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			appRxValid <= 1'b0;
			appRxTlp   <= '0;
			appRxVfHit <= 1'b0;
		end else if (toApp) begin
			appRxValid <= 1'b1;
			appRxTlp   <= coreRxTlp;
			appRxVfHit <= isMem && coreRxTlp.func >= scb_pkg::PF_LIM;
		end else if (appRxReady) begin
			appRxValid <= 1'b0;
		end
	end

	// Management port routing
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lmAck     <= 1'b0;
			lmRdata   <= '0;
			coreLmReq <= 1'b0;
			coreLmCmd <= '0;
		end else begin
			lmAck <= 1'b0;
			if (lmLocal) begin
				lmAck   <= 1'b1;
				lmRdata <= (lmF < scb_pkg::FN_LIM && cfgKnown(lmCmd.addr[7:0]))
					? cfgRead(lmF, lmCmd.addr[7:0]) : '0;
			end else if (coreLmReq && coreLmAck) begin
				coreLmReq <= 1'b0;
				lmAck     <= 1'b1;
				lmRdata   <= coreLmRdata;
			end else if (lmReq && !lmAck && !coreLmReq && !lmCmd.addr[scb_pkg::LM_SEL]) begin
				coreLmReq <= 1'b1;
				coreLmCmd <= lmCmd;
			end
		end
	end

	// Shadow of virtual-function control writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shadowValid <= 1'b0;
			shadowFunc  <= '0;
			shadowCtl   <= '0;
		end else begin
			shadowValid <= wrEn && wrReg == scb_pkg::R_CTL && wrF >= scb_pkg::PF_LIM;
			shadowFunc  <= wrF;
			shadowCtl   <= wrData[7:0];
		end
	end

	// Checks on the guarded behaviour
	AST_RST_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
		periphS2 && !coreRstn |=> coreRstn) else $error("core reset not released");
	AST_MSI_PF: assert property (@(posedge clk) disable iff (!rstn)
		intValid && intTlp.tag == scb_pkg::T_MSI && intTlp.kind == scb_pkg::K_MWR
		|-> intTlp.func < scb_pkg::PF_LIM) else $error("MSI from virtual function");
	AST_INTX: assert property (@(posedge clk) disable iff (!rstn)
		$changed(intxSent) |-> intValid && intTlp.tag == (intxSent ? scb_pkg::M_INTA_ON
		: scb_pkg::M_INTA_OFF)) else $error("INTx message mismatch");
	AST_BAR_DROP: assert property (@(posedge clk) disable iff (!rstn)
		rxFire && isMem && !barHit |=> !appRxValid) else $error("BAR miss forwarded");
	AST_UR_ID: assert property (@(posedge clk) disable iff (!rstn)
		rxFire && coreRxTlp.kind == scb_pkg::K_MRD && !barHit |=> intValid
		&& intTlp.addr[2:0] == scb_pkg::CPL_UR && intTlp.reqId == $past(coreRxTlp.reqId)
		&& intTlp.tag == $past(coreRxTlp.tag)) else $error("UR completion wrong");
	AST_CREDIT: assert property (@(posedge clk) disable iff (!rstn)
		coreTxValid |-> credit != '0) else $error("send without credit");
	AST_FWD: assert property (@(posedge clk) disable iff (!rstn)
		toApp |=> appRxValid && appRxTlp == $past(coreRxTlp)) else $error("receive altered");
	AST_CFG_CPL: assert property (@(posedge clk) disable iff (!rstn)
		rxFire && isCfg |=> intValid && (intTlp.kind == scb_pkg::K_CPL
		|| intTlp.kind == scb_pkg::K_CPLD)) else $error("no config completion");
	AST_TX_PASS: assert property (@(posedge clk) disable iff (!rstn)
		appTxValid && appTxReady |=> bufValid && coreTxTlp == $past(appTxTlp))
		else $error("application packet altered");
	COV_UR: cover property (@(posedge clk) disable iff (!rstn)
		rxFire && coreRxTlp.kind == scb_pkg::K_MRD && !barHit);
	COV_BLOCK: cover property (@(posedge clk) disable iff (!rstn) bufValid && credit == '0);
	COV_MSIX: cover property (@(posedge clk) disable iff (!rstn)
		intValid && intTlp.tag == scb_pkg::T_MSIX);
endmodule // scb_sriov_bridge

// ### scb_pkg.sv
// Constants and carrier types for the SR-IOV configuration and BAR bridge
package scb_pkg;
	localparam int              PF_NUM       = 8;
	localparam int              VF_NUM       = 2048;
	localparam int              FN_NUM       = PF_NUM + VF_NUM;
	localparam int              FN_W         = 12;
	localparam logic [11:0]     PF_LIM       = 12'h008;
	localparam logic [11:0]     FN_LIM       = 12'h808;
	localparam int              CFG_TIME_MS  = 100;
	localparam int              CLK_KHZ      = 20000;
	localparam int              CFG_BUDGET   = CFG_TIME_MS * CLK_KHZ;
	localparam int              HOLD_W       = 22;
	// Packet kinds
	localparam logic [7:0]      K_MRD        = 8'h00;
	localparam logic [7:0]      K_MWR        = 8'h40;
	localparam logic [7:0]      K_CFGRD      = 8'h04;
	localparam logic [7:0]      K_CFGWR      = 8'h44;
	localparam logic [7:0]      K_CPL        = 8'h0A;
	localparam logic [7:0]      K_CPLD       = 8'h4A;
	localparam logic [7:0]      K_MSG        = 8'h30;
	// Message codes and internal write markers, carried in the tag field; completion status, carried in the low address bits
	localparam logic [7:0]      M_INTA_ON    = 8'h20;
	localparam logic [7:0]      M_INTA_OFF   = 8'h24;
	localparam logic [7:0]      M_ERR_NF     = 8'h31;
	localparam logic [7:0]      T_MSI        = 8'h01;
	localparam logic [7:0]      T_MSIX       = 8'h02;
	localparam logic [2:0]      CPL_SC       = 3'h0;
	localparam logic [2:0]      CPL_UR       = 3'h1;
	// Configuration register numbers
	localparam logic [7:0]      R_CTL        = 8'h01;
	localparam logic [7:0]      R_BAR        = 8'h04;
	localparam logic [7:0]      R_MSI_ADDR   = 8'h14;
	localparam logic [7:0]      R_MSI_DATA   = 8'h15;
	localparam logic [7:0]      R_MSIX_TBL   = 8'h18;
	localparam logic [7:0]      R_MSIX_PBA   = 8'h19;
	localparam logic [31:0]     MSIX_TBL_PTR = 32'h0000_2000;
	localparam logic [31:0]     MSIX_PBA_PTR = 32'h0000_3000;
	localparam logic [31:0]     BAR_MASK     = 32'hFFF0_0000;
	// Control field bits
	localparam int              C_MEM        = 0;
	localparam int              C_MSI        = 1;
	localparam int              C_MSIX       = 2;
	localparam int              C_ATS        = 3;
	localparam int              C_TPH        = 4;
	localparam int              LM_SEL       = 23;
	localparam int              LM_FN        = 8;
	localparam logic [7:0]      CREDIT_INIT  = 8'h08;

	typedef struct packed {
		logic [7:0]      kind;
		logic [FN_W-1:0] func;
		logic [15:0]     reqId;
		logic [7:0]      tag;
		logic [31:0]     addr;
		logic [31:0]     data;
	} scb_tlp_s;

	typedef struct packed {
		logic        write;
		logic [23:0] addr;
		logic [31:0] wdata;
	} scb_lm_s;

	typedef enum logic [1:0] {
		RST_HOLD = 2'b01,
		RST_RUN  = 2'b10
	} scb_rst_e;
endpackage

// ### scb_core_model.sv
// Core-side partner model: transmit sink with stalls, credit return, management port
`timescale 1ns/1ns
module scb_core_model (
	input  logic             clk,
	input  logic             rstn,
	input  logic             slow,
	input  logic             holdCredit,
	input  logic             coreTxValid,
	output logic             coreTxReady,
	output logic             creditReturn,
	input  logic             coreLmReq,
	input  scb_pkg::scb_lm_s coreLmCmd,
	output logic             coreLmAck,
	output logic [31:0]      coreLmRdata
);
	logic [1:0] txWait;
	logic [3:0] owed;
	logic [1:0] lmWait;
	logic       take;
	logic       give;

	// Slow mode stalls each beat so the bridge must hold it
	assign coreTxReady = coreTxValid && (!slow || txWait == 2'h2);
	assign take        = coreTxValid && coreTxReady;
	assign give        = !holdCredit && owed != 4'h0 && !creditReturn;

	// Stall counter for the current beat
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			txWait <= 2'h0;
		else if (!coreTxValid || coreTxReady)
			txWait <= 2'h0;
		else
			txWait <= txWait + 2'h1;
	end

	// Credits come back only when released, never more than were used
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			owed         <= 4'h0;
			creditReturn <= 1'b0;
		end else begin
			owed         <= owed + {3'h0, take} - {3'h0, give};
			creditReturn <= give;
		end
	end

	// Management responder; stale data is inverted every idle cycle, so the last answer reappears every other cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lmWait      <= 2'h0;
			coreLmAck   <= 1'b0;
			coreLmRdata <= 32'h0;
		end else if (coreLmReq && !coreLmAck && lmWait == 2'h2) begin
			lmWait      <= 2'h0;
			coreLmAck   <= 1'b1;
			coreLmRdata <= {8'hC0, coreLmCmd.addr};
		end else begin
			lmWait      <= (coreLmReq && !coreLmAck) ? lmWait + 2'h1 : 2'h0;
			coreLmAck   <= 1'b0;
			coreLmRdata <= ~coreLmRdata;
		end
	end
endmodule // scb_core_model

// ### scb_sriov_bridge_tb.sv
// Self-checking bench for the SR-IOV configuration and BAR bridge
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module scb_sriov_bridge_tb;
	typedef struct {
		scb_pkg::scb_tlp_s tlp;
		int                dst;
		logic [7:0]        kind;
		logic [31:0]       exp;
	} scb_row_s;
	logic clk = 1'b0, rstn = 1'b0, peripheryDone = 1'b0, slow = 1'b0, holdCredit = 1'b0;
	logic coreRxValid = 1'b0, appRxReady = 1'b1, appTxValid = 1'b0, lmReq = 1'b0;
	logic msiReq = 1'b0, msixReq = 1'b0, intxSts = 1'b0;
	scb_pkg::scb_tlp_s coreRxTlp = '0, appTxTlp = '0, appRxTlp, coreTxTlp, rxQ[$], txQ[$];
	scb_pkg::scb_lm_s  lmCmd = '0, coreLmCmd;
	logic [11:0] intFunc = 12'h0, shadowFunc, shFunc;
	logic [4:0]  msiVector = 5'h03;
	logic [31:0] msixAddr = 32'hFEE0_1000, msixData = 32'h0000_0077;
	logic [31:0] lmRdata, coreLmRdata, rd;
	logic [7:0]  shadowCtl, shCtl;
	logic coreRstn, cfgTimeMiss, coreRxReady, appRxValid, appRxVfHit, appTxReady, coreTxValid;
	logic coreTxReady, creditReturn, intAck, lmAck, coreLmReq, coreLmAck, shadowValid;
	logic rxVf[$];
	logic refClk = 1'b0;
	int   errors = 0, samples_checked = 0, refTicks = 0;
	scb_row_s rows[16];

	// Short budget keeps the reset-hold timeout reachable in simulation
	scb_sriov_bridge #(.CFG_BUDGET(50)) scb_sriov_bridge_i (.*);
	scb_core_model scb_core_model_i (.*);

	always #25 clk = ~clk;

	// Core reference clock, five periods to each bridge clock
	always #5 refClk = ~refClk;
	always @(posedge refClk) refTicks++;

	// Record every accepted beat and every shadow update
	always @(posedge clk) begin
		if (appRxValid && appRxReady) begin
			rxQ.push_back(appRxTlp);
			rxVf.push_back(appRxVfHit);
		end
		if (coreTxValid && coreTxReady)
			txQ.push_back(coreTxTlp);
		if (shadowValid === 1'b1) begin
			shFunc = shadowFunc;
			shCtl  = shadowCtl;
		end
	end

	function automatic scb_pkg::scb_tlp_s mk(logic [7:0] k, logic [11:0] f, logic [7:0] t,
		logic [31:0] a, logic [31:0] d);
		return '{k, f, 16'h0A5C, t, a, d};
	endfunction

	function automatic scb_row_s r(logic [7:0] k, logic [11:0] f, logic [31:0] a,
		logic [31:0] d, int dst, logic [7:0] ek, logic [31:0] exp);
		return '{mk(k, f, 8'h00, a, d), dst, ek, exp};
	endfunction

	task automatic results();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic hang();
		`CHK(1'b0, 1'b1)
		results();
	endtask

	task automatic waitQ(ref scb_pkg::scb_tlp_s q[$], input int n);
		int i;
		for (i = 0; i < 300 && q.size() < n; i++) @(negedge clk);
		if (q.size() < n) hang();
	endtask

	// Offer one beat; ready seen between edges means the next rising edge takes it
	task automatic send(input bit tx, input scb_pkg::scb_tlp_s t);
		int i;
		@(negedge clk);
		if (tx) begin
			appTxValid = 1'b1;
			appTxTlp   = t;
		end else begin
			coreRxValid = 1'b1;
			coreRxTlp   = t;
		end
		for (i = 0; i < 3000; i++) begin
			if ((tx ? appTxReady : coreRxReady) === 1'b1) break;
			@(negedge clk);
		end
		@(negedge clk);
		appTxValid  = 1'b0;
		coreRxValid = 1'b0;
		if (i == 3000) hang();
	endtask

	// Interrupt and management requests are levels held until acknowledged
	task automatic req(input int kind, input logic [11:0] f, input logic [23:0] a,
		input logic [31:0] d);
		int i;
		@(negedge clk);
		intFunc = f;
		msiReq  = (kind == 0);
		msixReq = (kind == 1);
		lmReq   = (kind >= 2);
		lmCmd   = '{kind == 3, a, d};
		for (i = 0; i < 300; i++) begin
			@(negedge clk);
			if ((kind >= 2 ? lmAck : intAck) === 1'b1) break;
		end
		rd = lmRdata;
		@(negedge clk);
		{msiReq, msixReq, lmReq} = 3'h0;
		if (i == 300) hang();
	endtask

	initial begin
		int i, n;
		rows[0]  = r(scb_pkg::K_CFGWR, 12'h000, 32'h1, 32'h1F, 1, scb_pkg::K_CPL, 32'h0);
		rows[1]  = r(scb_pkg::K_CFGWR, 12'h000, 32'h4, 32'h1000_0000, 1, scb_pkg::K_CPL, 32'h0);
		rows[2]  = r(scb_pkg::K_CFGRD, 12'h000, 32'h4, 32'h0, 1, scb_pkg::K_CPLD, 32'h1000_0000);
		rows[3]  = r(scb_pkg::K_CFGRD, 12'h000, 32'h18, 32'h0, 1, scb_pkg::K_CPLD,
			scb_pkg::MSIX_TBL_PTR);
		rows[4]  = r(scb_pkg::K_CFGWR, 12'h000, 32'h14, 32'hFEE0_0000, 1, scb_pkg::K_CPL, 32'h0);
		rows[5]  = r(scb_pkg::K_CFGWR, 12'h000, 32'h15, 32'h4000, 1, scb_pkg::K_CPL, 32'h0);
		rows[6]  = r(scb_pkg::K_CFGWR, 12'h008, 32'h1, 32'h5, 1, scb_pkg::K_CPL, 32'h0);
		rows[7]  = r(scb_pkg::K_CFGWR, 12'h008, 32'h4, 32'h3000_0000, 1, scb_pkg::K_CPL, 32'h0);
		rows[8]  = r(scb_pkg::K_MRD, 12'h000, 32'h1000_0010, 32'h0, 0, 8'h00, 32'h0);
		rows[9]  = r(scb_pkg::K_MWR, 12'h008, 32'h3000_0020, 32'h1234_5678, 0, 8'h00, 32'h1);
		rows[10] = r(scb_pkg::K_MWR, 12'h000, 32'h2000_0000, 32'h55, 2, 8'h00, 32'h0);
		rows[11] = r(scb_pkg::K_MRD, 12'h008, 32'h1000_0000, 32'h0, 1, scb_pkg::K_CPL, 32'h1);
		rows[12] = r(scb_pkg::K_CPLD, 12'h000, 32'h0, 32'hBEEF, 0, 8'h00, 32'h0);
		rows[13] = r(scb_pkg::K_MSG, 12'h000, 32'h0, 32'h0, 0, 8'h00, 32'h0);
		rows[14] = r(scb_pkg::K_CFGRD, 12'h000, 32'h19, 32'h0, 1, scb_pkg::K_CPLD,
			scb_pkg::MSIX_PBA_PTR);
		rows[15] = r(scb_pkg::K_CFGRD, 12'h008, 32'h14, 32'h0, 1, scb_pkg::K_CPLD, 32'h0);
		// Reset, then let the core-hold timer run out before the periphery is ready
		repeat (16) @(negedge clk);
		`CHK(refTicks, 16 * 100000 / scb_pkg::CLK_KHZ)
		rstn = 1'b1;
		repeat (60) @(negedge clk);
		// Store sweep still running: receive refused, transmit already open
		`CHK({coreRxReady, appTxReady}, 2'b01)
		`CHK(cfgTimeMiss, 1'b1)
		`CHK(coreRstn, 1'b0)
		peripheryDone = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(coreRstn, 1'b1)
		// Ordinary receive cases
		foreach (rows[i]) begin
			rows[i].tlp.tag = 8'h10 + 8'(i);
			n = (rows[i].dst == 0) ? rxQ.size() : txQ.size() + rxQ.size();
			send(1'b0, rows[i].tlp);
			if (rows[i].dst == 0) begin
				waitQ(txQ, 0);
				for (int j = 0; j < 300 && rxQ.size() <= n; j++) @(negedge clk);
				if (rxQ.size() <= n) hang();
				`CHK(rxQ[n], rows[i].tlp)
				`CHK(rxVf[n], rows[i].exp[0])
			end else if (rows[i].dst == 1) begin
				n = txQ.size();
				waitQ(txQ, n + 1);
				`CHK(txQ[n].kind, rows[i].kind)
				`CHK({txQ[n].reqId, txQ[n].tag}, {rows[i].tlp.reqId, rows[i].tlp.tag})
				`CHK(rows[i].kind == scb_pkg::K_CPLD ? txQ[n].data : 32'(txQ[n].addr[2:0]),
					rows[i].exp)
			end else begin
				repeat (20) @(negedge clk);
				`CHK(txQ.size() + rxQ.size(), n)
			end
		end
		// Application stalls receive: the beat stands and the link is refused
		appRxReady = 1'b0;
		n = rxQ.size();
		send(1'b0, mk(scb_pkg::K_CPLD, 12'h001, 8'h77, 32'h0, 32'h0000_1234));
		repeat (5) @(negedge clk);
		`CHK({appRxValid, coreRxReady, appRxTlp.tag}, {2'b10, 8'h77})
		appRxReady = 1'b1;
		waitQ(rxQ, n + 1);
		`CHK(rxQ[n].data, 32'h0000_1234)
		// Configuration to a nonexistent function: UR then an error message
		n = txQ.size();
		send(1'b0, mk(scb_pkg::K_CFGRD, 12'h900, 8'h5A, 32'h1, 32'h0));
		waitQ(txQ, n + 2);
		`CHK(txQ[n].addr[2:0], scb_pkg::CPL_UR)
		`CHK({txQ[n + 1].kind, txQ[n + 1].tag}, {scb_pkg::K_MSG, scb_pkg::M_ERR_NF})
		// MSI on a PF, MSI on a VF (dropped), MSI-X on a VF, then legacy level
		n = txQ.size();
		req(0, 12'h000, 24'h0, 32'h0);
		req(0, 12'h008, 24'h0, 32'h0);
		req(1, 12'h008, 24'h0, 32'h0);
		repeat (10) @(negedge clk);
		`CHK(txQ.size(), n + 2)
		`CHK({txQ[n].tag, txQ[n].addr, txQ[n].data}, {scb_pkg::T_MSI, 64'hFEE0_0000_0000_4003})
		`CHK({txQ[n + 1].addr, txQ[n + 1].data}, {msixAddr, msixData})
		intxSts = 1'b1;
		waitQ(txQ, n + 3);
		intxSts = 1'b0;
		waitQ(txQ, n + 4);
		`CHK({txQ[n + 2].tag, txQ[n + 3].tag}, {scb_pkg::M_INTA_ON, scb_pkg::M_INTA_OFF})
		// Management: bridge register write and read, then a core access
		req(3, 12'h0, 24'h80_0801, 32'h1D);
		repeat (2) @(negedge clk);
		`CHK({shFunc, shCtl}, {12'h008, 8'h1D})
		req(2, 12'h0, 24'h80_0801, 32'h0);
		`CHK(rd, 32'h1D)
		req(2, 12'h0, 24'h00_0123, 32'h0);
		`CHK(rd, 32'hC000_0123)
		// Nine sends against eight credits with a stalling core
		repeat (40) @(negedge clk);
		slow       = 1'b1;
		holdCredit = 1'b1;
		n = txQ.size();
		for (i = 0; i < 9; i++)
			send(1'b1, mk(scb_pkg::K_MWR, 12'h0, 8'(i), 32'h4000_0000, 32'hCAFE_0000 + 32'(i)));
		repeat (20) @(negedge clk);
		`CHK(txQ.size(), n + 8)
		holdCredit = 1'b0;
		waitQ(txQ, n + 9);
		for (i = 0; i < 9; i++)
			`CHK(txQ[n + i], mk(scb_pkg::K_MWR, 12'h0, 8'(i), 32'h4000_0000, 32'hCAFE_0000 + 32'(i)))
		results();
	end
endmodule // scb_sriov_bridge_tb
